// ---- logic/ctl_word_shifter.sv ----
// Serial control-port word assembler.
// Assumes ctlClk, ctlData and ctlLatch are already synchronous to core_clk.
`timescale 1ns/1ps
module ctl_word_shifter (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ctlClk,
  input wire logic ctlData,
  input wire logic ctlLatch,
  output mic_route_pkg::ctl_write_s wrWord,
  output logic wrValid
);
  import mic_route_pkg::*;

  logic [15:0] shift_ff;
  logic [4:0] count_ff;
  logic clkPrev_ff;
  logic latchPrev_ff;
  ctl_write_s wrWord_ff;
  logic wrValid_ff;
  wire clkRise = ctlClk & ~clkPrev_ff;
  wire latchRise = ctlLatch & ~latchPrev_ff;
  // Only whole words commit; a short burst is dropped
  wire wordDone = latchRise && (count_ff > WORD_BITS_M1);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      shift_ff <= 16'h0000;
      count_ff <= 5'h00;
      clkPrev_ff <= 1'b0;
      latchPrev_ff <= 1'b1;
      wrWord_ff <= '0;
      wrValid_ff <= 1'b0;
    end else begin
      clkPrev_ff <= ctlClk;
      latchPrev_ff <= ctlLatch;
      wrValid_ff <= wordDone;
      if (wordDone) begin
        wrWord_ff <= shift_ff;
      end
      if (latchRise) begin
        count_ff <= 5'h00;
      end else if (clkRise && !ctlLatch) begin
        shift_ff <= {shift_ff[14:0], ctlData};
        if (count_ff != 5'h1f) begin
          count_ff <= count_ff + 5'h01;
        end
      end
    end
  end

  assign wrWord = wrWord_ff;
  assign wrValid = wrValid_ff;
endmodule

// ---- logic/mic_input_routing_ctrl.sv ----
// Mic input routing and input amplifier enable control registers.
// Assumes the serial control port pins are already synchronous to core_clk.
`timescale 1ns/1ps
module mic_input_routing_ctrl (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ctlClk,
  input wire logic ctlData,
  input wire logic ctlLatch,
  output mic_route_pkg::route_ctrl_s routeCtrl,
  output logic [8:0] inputRoutingReg,
  output logic [8:0] pwrMgmtTwoReg
);
  import mic_route_pkg::*;

  // ********************
  // Port word capture
  // ********************
  ctl_write_s wrWord;
  logic wrValid;

  ctl_word_shifter u_shifter (
    .core_clk(core_clk),
    .resetn(resetn),
    .ctlClk(ctlClk),
    .ctlData(ctlData),
    .ctlLatch(ctlLatch),
    .wrWord(wrWord),
    .wrValid(wrValid)
  );

  // ********************
  // Register file
  // ********************
  logic [8:0] inRoute_ff;
  logic [8:0] pwrTwo_ff;
  route_ctrl_s route_ff;
  wire hitRoute = wrValid && (wrWord.addr == INPUT_ROUTING_ADDR);
  wire hitPwr = wrValid && (wrWord.addr == PWR_MGMT_TWO_ADDR);
  // Routing bits outside INPUT_ROUTING_MASK are cleared; stored bits this block does not own steer nothing here
  wire [8:0] nxt_inRoute = hitRoute ? (wrWord.data & INPUT_ROUTING_MASK) : inRoute_ff;
  wire [8:0] nxt_pwrTwo = hitPwr ? (wrWord.data & PWR_MGMT_TWO_MASK) : pwrTwo_ff;
  route_ctrl_s nxt_route;
  route_ctrl_s routeReset;

  // ********************
  // Field decode
  // ********************
  // Every control is a plain tap of the next register image, so a control
  // and its read-back bit always change on the same edge
  wire nxtPosSelect = nxt_inRoute[POS_SEL_BIT];
  wire nxtNegConnect = nxt_inRoute[NEG_CONN_BIT];
  wire nxtAuxConnect = nxt_inRoute[AUX_CONN_BIT];
  wire nxtAmpEnable = nxt_pwrTwo[AMP_EN_BIT];
  // Gain reaches the positive pin path only while that pin feeds the amplifier
  wire nxtGainOnPos = nxtPosSelect;

  assign nxt_route = '{
    posTerminalSourceSelect: nxtPosSelect,
    negPinConnect: nxtNegConnect,
    auxBufferConnect: nxtAuxConnect,
    inputAmpEnable: nxtAmpEnable,
    gainOnPosPath: nxtGainOnPos
  };

  // Reset image built from the register reset words, so the decoded controls
  // can never disagree with the read-back after reset
  assign routeReset = '{
    posTerminalSourceSelect: INPUT_ROUTING_RESET[POS_SEL_BIT],
    negPinConnect: INPUT_ROUTING_RESET[NEG_CONN_BIT],
    auxBufferConnect: INPUT_ROUTING_RESET[AUX_CONN_BIT],
    inputAmpEnable: PWR_MGMT_TWO_RESET[AMP_EN_BIT],
    gainOnPosPath: INPUT_ROUTING_RESET[POS_SEL_BIT]
  };

  // ********************
  // Register update
  // ********************
  // Outputs load from next-state so the write lands on the same edge
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      inRoute_ff <= INPUT_ROUTING_RESET;
      pwrTwo_ff <= PWR_MGMT_TWO_RESET;
      route_ff <= routeReset;
    end else begin
      inRoute_ff <= nxt_inRoute;
      pwrTwo_ff <= nxt_pwrTwo;
      route_ff <= nxt_route;
    end
  end

  assign routeCtrl = route_ff;
  assign inputRoutingReg = inRoute_ff;
  assign pwrMgmtTwoReg = pwrTwo_ff;

  // ********************
  // Checks
  // ********************
  a_pos_select_follows: assert property (@(posedge core_clk) disable iff (!resetn)
    hitRoute |=> routeCtrl.posTerminalSourceSelect == $past(wrWord.data[0]))
    else $error("positive select not applied");
  a_neg_connect_follows: assert property (@(posedge core_clk) disable iff (!resetn)
    hitRoute |=> routeCtrl.negPinConnect == $past(wrWord.data[1]))
    else $error("negative connect not applied");
  a_aux_connect_follows: assert property (@(posedge core_clk) disable iff (!resetn)
    hitRoute |=> routeCtrl.auxBufferConnect == $past(wrWord.data[2]))
    else $error("aux connect not applied");
  a_amp_enable_follows: assert property (@(posedge core_clk) disable iff (!resetn)
    hitPwr |=> routeCtrl.inputAmpEnable == $past(wrWord.data[2]))
    else $error("amp enable not applied");
  a_amp_enable_holds: assert property (@(posedge core_clk) disable iff (!resetn)
    !hitPwr |=> $stable(routeCtrl.inputAmpEnable))
    else $error("amp enable changed without write");
  a_gain_pos_path: assert property (@(posedge core_clk) disable iff (!resetn)
    routeCtrl.gainOnPosPath == routeCtrl.posTerminalSourceSelect)
    else $error("gain path disagrees with select");
  a_reset_defaults: assert property (@(posedge core_clk)
    !resetn |=> routeCtrl.posTerminalSourceSelect && routeCtrl.negPinConnect && !routeCtrl.auxBufferConnect)
    else $error("routing reset value wrong");
  a_route_stable: assert property (@(posedge core_clk) disable iff (!resetn)
    !hitRoute |=> $stable(inputRoutingReg))
    else $error("routing changed without write");

  // ********************
  // Reset values
  // ********************
  a_route_reg_reset: assert property (@(posedge core_clk)
    !resetn
    |=> inputRoutingReg == INPUT_ROUTING_RESET)
    else $error("routing register reset value wrong");

  a_pwr_reg_reset: assert property (@(posedge core_clk)
    !resetn
    |=> pwrMgmtTwoReg == PWR_MGMT_TWO_RESET)
    else $error("power register reset value wrong");

  a_amp_reset_off: assert property (@(posedge core_clk)
    !resetn
    |=> !routeCtrl.inputAmpEnable)
    else $error("amplifier enabled out of reset");

  a_gain_reset_on: assert property (@(posedge core_clk)
    !resetn
    |=> routeCtrl.gainOnPosPath)
    else $error("gain path off out of reset");

  // ********************
  // Write acceptance
  // ********************
  a_route_reg_loads: assert property (@(posedge core_clk) disable iff (!resetn)
    hitRoute
    |=> inputRoutingReg == ($past(wrWord.data) & INPUT_ROUTING_MASK))
    else $error("routing write not stored");

  a_pwr_reg_loads: assert property (@(posedge core_clk) disable iff (!resetn)
    hitPwr
    |=> pwrMgmtTwoReg == ($past(wrWord.data) & PWR_MGMT_TWO_MASK))
    else $error("power write not stored");

  a_pwr_reg_holds: assert property (@(posedge core_clk) disable iff (!resetn)
    !hitPwr
    |=> $stable(pwrMgmtTwoReg))
    else $error("power register changed without write");

  a_route_ctrl_holds: assert property (@(posedge core_clk) disable iff (!resetn)
    !hitRoute
    |=> $stable(routeCtrl.posTerminalSourceSelect) && $stable(routeCtrl.negPinConnect)
      && $stable(routeCtrl.auxBufferConnect))
    else $error("routing control changed without write");

  // An unknown address is dropped without any sign to the host
  a_unmapped_ignored: assert property (@(posedge core_clk) disable iff (!resetn)
    wrValid && !hitRoute && !hitPwr
    |=> $stable(inputRoutingReg) && $stable(pwrMgmtTwoReg))
    else $error("unmapped write changed a register");

  a_gain_follows_write: assert property (@(posedge core_clk) disable iff (!resetn)
    hitRoute
    |=> routeCtrl.gainOnPosPath == $past(wrWord.data[POS_SEL_BIT]))
    else $error("gain path not updated by write");

  // ********************
  // Control coherence
  // ********************
  a_ctrl_matches_route: assert property (@(posedge core_clk) disable iff (!resetn)
    routeCtrl.posTerminalSourceSelect == inputRoutingReg[POS_SEL_BIT]
    && routeCtrl.negPinConnect == inputRoutingReg[NEG_CONN_BIT]
    && routeCtrl.auxBufferConnect == inputRoutingReg[AUX_CONN_BIT])
    else $error("routing control disagrees with register");

  a_ctrl_matches_pwr: assert property (@(posedge core_clk) disable iff (!resetn)
    routeCtrl.inputAmpEnable == pwrMgmtTwoReg[AMP_EN_BIT])
    else $error("amp enable disagrees with register");

  // Routing bits that are not stored must always read zero
  for (genvar i = 0; i < DATA_W; i++) begin : g_route_unstored
    if (!INPUT_ROUTING_MASK[i]) begin : g_zero
      a_unstored_bit_zero: assert property (@(posedge core_clk) disable iff (!resetn)
        inputRoutingReg[i] == 1'b0)
        else $error("unstored routing bit reads one");
    end
  end

  // ********************
  // Port capture
  // ********************
  // A commit comes only from the one-cycle latch rising edge, so it is one pulse
  a_commit_one_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
    wrValid
    |=> !wrValid)
    else $error("commit lasted more than one cycle");

  a_commit_needs_latch: assert property (@(posedge core_clk) disable iff (!resetn)
    !ctlLatch
    |=> !wrValid)
    else $error("commit without latch rising");
endmodule

// ---- logic/mic_route_pkg.sv ----
// Package for the mic input routing control block.
// Assumes a 9-bit register word written over a serial control port word of 16 bits.
package mic_route_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 9;
  localparam logic [6:0] PWR_MGMT_TWO_ADDR = 7'h02;
  localparam logic [6:0] INPUT_ROUTING_ADDR = 7'h2c;
  localparam int POS_SEL_BIT = 0;
  localparam int NEG_CONN_BIT = 1;
  localparam int AUX_CONN_BIT = 2;
  localparam int AMP_EN_BIT = 2;
  localparam logic [8:0] INPUT_ROUTING_RESET = 9'h003;
  localparam logic [8:0] PWR_MGMT_TWO_RESET = 9'h000;
  localparam logic [8:0] INPUT_ROUTING_MASK = 9'h00f;
  localparam logic [8:0] PWR_MGMT_TWO_MASK = 9'h1ff;
  localparam int WORD_BITS = 16;
  localparam logic [4:0] WORD_BITS_M1 = 5'h0f;

  typedef struct packed {
    logic posTerminalSourceSelect;
    logic negPinConnect;
    logic auxBufferConnect;
    logic inputAmpEnable;
    logic gainOnPosPath;
  } route_ctrl_s;

  typedef struct packed {
    logic [6:0] addr;
    logic [8:0] data;
  } ctl_write_s;
endpackage

// ---- testbench/mic_input_routing_ctrl_tb.sv ----
// Self-checking bench for the mic input routing control registers.
// Assumes the control port is driven directly, with levels held two core_clk cycles.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module mic_input_routing_ctrl_tb;
  import mic_route_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic ctlClk = 1'b0;
  logic ctlData = 1'b0;
  logic ctlLatch = 1'b1;
  route_ctrl_s routeCtrl;
  logic [8:0] inputRoutingReg;
  logic [8:0] pwrMgmtTwoReg;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;

  mic_input_routing_ctrl dut (
    .core_clk(core_clk),
    .resetn(resetn),
    .ctlClk(ctlClk),
    .ctlData(ctlData),
    .ctlLatch(ctlLatch),
    .routeCtrl(routeCtrl),
    .inputRoutingReg(inputRoutingReg),
    .pwrMgmtTwoReg(pwrMgmtTwoReg)
  );

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  // ********************
  // Port access
  // ********************
  // Sends the top nb bits of the word; fewer than 16 must be ignored
  task automatic wr(input logic [6:0] a, input logic [8:0] d, input int nb);
    logic [15:0] w;
    w = {a, d};
    ctlLatch <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      ctlClk <= 1'b0;
      ctlData <= w[15-i];
      repeat (2) @(posedge core_clk);
      ctlClk <= 1'b1;
      repeat (2) @(posedge core_clk);
    end
    ctlLatch <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hang guard: every scenario together needs well under 2000 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      summarize();
    end
  end

  // ********************
  // Scenarios
  // ********************
  initial begin
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    `CHK("routing reset", 9'h003, inputRoutingReg)
    `CHK("power reset", 9'h000, pwrMgmtTwoReg)
    `CHK("ctrl reset", 5'b11001, routeCtrl)
    wr(INPUT_ROUTING_ADDR, 9'h1fe, 16);
    `CHK("routing single", 9'h00e, inputRoutingReg)
    `CHK("ctrl single", 5'b01100, routeCtrl)
    wr(INPUT_ROUTING_ADDR, 9'h005, 16);
    `CHK("ctrl aux", 5'b10101, routeCtrl)
    wr(PWR_MGMT_TWO_ADDR, 9'h1fb, 16);
    `CHK("power off", 9'h1fb, pwrMgmtTwoReg)
    `CHK("ctrl off", 5'b10101, routeCtrl)
    wr(PWR_MGMT_TWO_ADDR, 9'h004, 16);
    `CHK("ctrl on", 5'b10111, routeCtrl)
    // Unmapped address and a short word must leave everything alone
    // Taken, the short burst would finish a power write of 0ff
    wr(7'h2d, 9'h004, 16);
    wr(7'h7f, 9'h1ff, 8);
    `CHK("power kept", 9'h004, pwrMgmtTwoReg)
    `CHK("routing kept", 9'h005, inputRoutingReg)
    // Second reset in mid-run restores defaults
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    `CHK("ctrl rereset", 5'b11001, routeCtrl)
    `CHK("routing rereset", 9'h003, inputRoutingReg)
    `CHK("power rereset", 9'h000, pwrMgmtTwoReg)
    summarize();
  end
endmodule
